// ### src/lmc_params.svh
// Constants for the control protocol and maintenance point classifier
`ifndef LMC_PARAMS_SVH
`define LMC_PARAMS_SVH
`define LMC_ADR_MODE      8'h00
`define LMC_ADR_MIP_CTRL  8'h04
`define LMC_ADR_STATUS    8'h08
`define LMC_ADR_TBL_IDX   8'h0C
`define LMC_ADR_L2CP      8'h10
`define LMC_ADR_MIP_CFG   8'h14
`define LMC_ADR_MIP_OPC   8'h18
`define LMC_ADR_MAC_LO    8'h1C
`define LMC_ADR_MAC_HI    8'h20
`define LMC_ADR_SVC       8'h24
`define LMC_ADR_PORT      8'h28
`define LMC_ADR_LAST      8'h2C
`define LMC_ADR_VID       8'h30
`define LMC_BPDU_BASE     48'h0180_C200_0000
`define LMC_GXRP_BASE     48'h0180_C200_0020
`define LMC_OPC_CCM       8'h01
`define LMC_OPC_LBM       8'h03
`define LMC_OPC_LTM       8'h05
`define LMC_OPC_RAPS      8'h28
`define LMC_N_PROFILES    75
`define LMC_N_SVC_PROF    64
`define LMC_N_PORT_PROF   11
`define LMC_N_MIP         128
`endif

// ### src/lmc_pkg.sv
// Types for the control protocol and maintenance point classifier
package lmc_pkg;
    typedef enum logic [1:0] {
        LMC_FWD_NORMAL  = 2'h0,
        LMC_FWD_TUNNEL  = 2'h1,
        LMC_FWD_PEER    = 2'h2,
        LMC_FWD_DISCARD = 2'h3
    } lmc_fwd_t;
    typedef enum logic [1:0] {
        LMC_ACT_NONE     = 2'h0,
        LMC_ACT_COPY     = 2'h1,
        LMC_ACT_REDIRECT = 2'h2,
        LMC_ACT_DISCARD  = 2'h3
    } lmc_act_t;
    typedef enum logic [1:0] {
        LMC_VID_ALL    = 2'h0,
        LMC_VID_UNTAG  = 2'h1,
        LMC_VID_MATCH  = 2'h2,
        LMC_VID_BOTH   = 2'h3
    } lmc_vid_t;
    typedef enum logic [1:0] {
        LMC_PP_NONE  = 2'h0,
        LMC_PP_CLM   = 2'h1,
        LMC_PP_OUTER = 2'h2,
        LMC_PP_INNER = 2'h3
    } lmc_pp_t;
    typedef enum logic [2:0] {
        LMC_ST_IDLE  = 3'b001,
        LMC_ST_SWEEP = 3'b010,
        LMC_ST_DONE  = 3'b100
    } lmc_state_t;
    typedef struct packed {
        logic        valid;
        logic [8:0]  service_index;
        logic [3:0]  port;
        logic [47:0] dmac;
        logic        upstream_redirect;
        logic        upstream_discard;
        logic [2:0]  class_of_service_id;
        logic        is_oam;
        logic [2:0]  maintenance_level;
        logic [7:0]  opcode;
        logic [1:0]  tag_count;
        logic [11:0] outer_vid;
        logic        maintenance_point_select_action;
        logic        tag_check_enable;
        logic [1:0]  oam_tag_count_action;
        logic [6:0]  maintenance_point_index;
    } lmc_frame_t;
    typedef struct packed {
        logic        valid;
        lmc_fwd_t    fwd;
        logic        cpu_copy;
        logic        cpu_redirect;
        logic        discard;
        logic [2:0]  cpu_queue;
        logic [2:0]  class_of_service_id;
        lmc_pp_t     pipeline_point;
    } lmc_result_t;
    typedef struct packed {
        lmc_fwd_t   fwd;
        logic [2:0] queue;
        logic       cos_override;
        logic [2:0] cos_value;
    } lmc_l2cp_t;
    typedef struct packed {
        logic       copy_once;
        logic [1:0] rate_class;
        logic       inner;
        logic [2:0] queue;
        lmc_act_t   generic_act;
        lmc_act_t   ring_act;
        logic       linktrace_en;
        logic       loopback_en;
        logic       continuity_en;
        logic [2:0] level;
        logic [7:0] generic_opcode;
        logic [47:0] mac;
    } lmc_mip_t;
endpackage : lmc_pkg

// ### src/lmc_classifier.sv
// Control protocol profile and maintenance point frame classifier
`timescale 1ns/1ps
`default_nettype none
`include "lmc_params.svh"
// Summary of operation
// - 75 profiles: 64 per service, 11 per port
// - Profile index zero selects port default profile
// - Non-service frames (service index zero) use port default profile
// - Entries 0-15 handle BPDU addresses by nibble
// - Entries 16-31 handle GXRP addresses
// - Entry selects tunnel, peer, discard and queue
// - Enabled override replaces class of service
// - Skip profiles for already redirected or discarded
// - Profile normal, redirect or discard gets lookup point; tunnel does not
// - 128 maintenance entries, all indexes valid
// - Run on select action; optional tag count
// - Four VID filter options
// - Level must equal entry level
// - Compare opcode with four plus generic
// - Continuity frames copied when enabled
// - Loopback redirected only on MAC match
// - Linktrace redirected when enabled
// - Ring frames copy, redirect or discard
// - Generic opcode copy, redirect or discard
// - Inner position still generates CPU copy
// - Copy-once sends one continuity frame, clears
// - Set command sets copy-once by rate mask
// - Any failed check ends maintenance processing
// - Entry selects outer or inner position for redirect or discard; copies get none
module lmc_classifier #(
    parameter int N_MIP = `LMC_N_MIP
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    input  wire lmc_pkg::lmc_frame_t frame_i,
    output lmc_pkg::lmc_result_t    result_o
);
    // Tables; the service table holds profile and maintenance indexes
    lmc_pkg::lmc_l2cp_t l2cp_mem [0:`LMC_N_PROFILES*32-1];
    lmc_pkg::lmc_mip_t  mip_mem  [0:N_MIP-1];
    logic [12:0] svc_mem  [0:511];
    logic [3:0]  port_mem [0:15];

    logic [11:0]          tbl_idx_reg;
    logic [3:0]           rate_mask_reg;
    logic                 set_cmd_reg;
    logic                 set_cmd_next;
    logic [7:0]           sweep_reg;
    logic [11:0]          vid_reg;
    lmc_pkg::lmc_vid_t    vid_mode_reg;
    lmc_pkg::lmc_state_t  state_reg;
    lmc_pkg::lmc_state_t  state_next;
    logic [31:0]          frames_reg;
    logic [31:0]          dat_reg;
    logic                 ack_reg;
    lmc_pkg::lmc_result_t res_reg;

    // Bus decode
    wire        bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire        bus_wr  = bus_req && wb_we_i && (wb_sel_i == 4'hF);
    wire [6:0]  idx7    = tbl_idx_reg[6:0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = bus_wr && (a == b);
    endfunction

    // Frame lookup
    wire [8:0]  svc     = frame_i.service_index;
    wire [12:0] svc_ent = svc_mem[svc];
    wire [5:0]  svc_prof = svc_ent[12:7];
    wire [6:0]  mp_index = svc_ent[6:0];
    wire [3:0]  port_prof = port_mem[frame_i.port];
    wire        use_port = (svc == 9'h000) || (svc_prof == 6'h00);
    wire [6:0]  prof = use_port ? (7'd64 + 7'(port_prof % 4'd11))
                                : {1'b0, svc_prof};
    wire        is_bpdu = frame_i.dmac[47:4] == 44'(`LMC_BPDU_BASE >> 4);
    wire        is_gxrp = frame_i.dmac[47:4] == 44'(`LMC_GXRP_BASE >> 4);
    wire [4:0]  ent_sel = {is_gxrp, frame_i.dmac[3:0]};
    wire [11:0] l2_addr = 12'({prof, ent_sel});
    lmc_pkg::lmc_l2cp_t l2e;
    assign l2e = l2cp_mem[l2_addr];
    wire        up_done = frame_i.upstream_redirect || frame_i.upstream_discard;
    wire        l2_apply = (is_bpdu || is_gxrp) && !up_done && !frame_i.is_oam;

    lmc_pkg::lmc_mip_t me;
    assign me = mip_mem[mp_index];
    wire tag_ok = !frame_i.tag_check_enable ||
                  (frame_i.tag_count == frame_i.oam_tag_count_action);
    wire vid_eq = (frame_i.tag_count == 2'd1) && (frame_i.outer_vid == vid_reg);
    wire untag  = frame_i.tag_count == 2'd0;
    wire vid_ok = (vid_mode_reg == lmc_pkg::LMC_VID_ALL) ||
                  (vid_mode_reg == lmc_pkg::LMC_VID_UNTAG && untag) ||
                  (vid_mode_reg == lmc_pkg::LMC_VID_MATCH && vid_eq) ||
                  (vid_mode_reg == lmc_pkg::LMC_VID_BOTH && (untag || vid_eq));
    wire mip_run = frame_i.is_oam && frame_i.maintenance_point_select_action
                   && tag_ok && vid_ok
                   && (frame_i.maintenance_level == me.level);
    wire op_ccm  = frame_i.opcode == `LMC_OPC_CCM;
    wire op_lbm  = frame_i.opcode == `LMC_OPC_LBM;
    wire op_ltm  = frame_i.opcode == `LMC_OPC_LTM;
    wire op_raps = frame_i.opcode == `LMC_OPC_RAPS;
    wire op_gen  = frame_i.opcode == me.generic_opcode;
    // Copy-once gates continuity copies when either mode is armed
    wire ccm_hit = op_ccm && (me.continuity_en || me.copy_once);
    lmc_pkg::lmc_act_t mact;
    assign mact = !mip_run ? lmc_pkg::LMC_ACT_NONE :
                  ccm_hit ? lmc_pkg::LMC_ACT_COPY :
                  (op_lbm && me.loopback_en && frame_i.dmac == me.mac)
                          ? lmc_pkg::LMC_ACT_REDIRECT :
                  (op_ltm && me.linktrace_en) ? lmc_pkg::LMC_ACT_REDIRECT :
                  op_raps ? me.ring_act :
                  op_gen  ? me.generic_act :
                  lmc_pkg::LMC_ACT_NONE;
    wire clear_once = frame_i.valid && mip_run && op_ccm && me.copy_once;

    // Result
    lmc_pkg::lmc_result_t res_next;
    always_comb begin
        res_next = '0;
        res_next.valid = frame_i.valid;
        res_next.class_of_service_id = frame_i.class_of_service_id;
        res_next.cpu_redirect = frame_i.upstream_redirect;
        res_next.discard = frame_i.upstream_discard;
        if (mact != lmc_pkg::LMC_ACT_NONE) begin
            res_next.cpu_queue = me.queue;
            res_next.cpu_copy = mact == lmc_pkg::LMC_ACT_COPY;
            res_next.cpu_redirect = mact == lmc_pkg::LMC_ACT_REDIRECT;
            res_next.discard = mact == lmc_pkg::LMC_ACT_DISCARD;
            if (mact != lmc_pkg::LMC_ACT_COPY) begin
                res_next.pipeline_point = me.inner ? lmc_pkg::LMC_PP_INNER
                                                   : lmc_pkg::LMC_PP_OUTER;
            end
        end else if (l2_apply) begin
            res_next.fwd = l2e.fwd;
            res_next.cpu_queue = l2e.queue;
            res_next.cpu_redirect = l2e.fwd == lmc_pkg::LMC_FWD_PEER;
            res_next.discard = l2e.fwd == lmc_pkg::LMC_FWD_DISCARD;
            if (l2e.cos_override) begin
                res_next.class_of_service_id = l2e.cos_value;
            end
            if (l2e.fwd != lmc_pkg::LMC_FWD_TUNNEL) begin
                res_next.pipeline_point = lmc_pkg::LMC_PP_CLM;
            end
        end
    end

    // Set command sweep over all entries
    wire sweep_end = sweep_reg == 8'(N_MIP - 1);
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lmc_pkg::LMC_ST_IDLE:  if (set_cmd_reg) state_next = lmc_pkg::LMC_ST_SWEEP;
            lmc_pkg::LMC_ST_SWEEP: if (sweep_end) state_next = lmc_pkg::LMC_ST_DONE;
            lmc_pkg::LMC_ST_DONE:  state_next = lmc_pkg::LMC_ST_IDLE;
            default:               state_next = lmc_pkg::LMC_ST_IDLE;
        endcase
    end
    wire mctrl_wr = hit(wb_adr_i, `LMC_ADR_MIP_CTRL);
    assign set_cmd_next = (mctrl_wr && wb_dat_i[4]) ||
                          (set_cmd_reg && state_reg != lmc_pkg::LMC_ST_DONE);
    wire [6:0] sw_idx = sweep_reg[6:0];
    wire sweep_set = state_reg == lmc_pkg::LMC_ST_SWEEP &&
                     rate_mask_reg[mip_mem[sw_idx].rate_class];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= lmc_pkg::LMC_ST_IDLE;
            set_cmd_reg   <= 1'b0;
            sweep_reg     <= 8'h00;
            rate_mask_reg <= 4'h0;
            tbl_idx_reg   <= 12'h000;
            vid_reg       <= 12'h000;
            vid_mode_reg  <= lmc_pkg::LMC_VID_ALL;
            frames_reg    <= 32'h0000_0000;
            res_reg       <= '0;
        end else begin
            state_reg   <= state_next;
            set_cmd_reg <= set_cmd_next;
            sweep_reg   <= (state_reg == lmc_pkg::LMC_ST_SWEEP) ? sweep_reg + 8'h01 : 8'h00;
            res_reg     <= res_next;
            if (frame_i.valid) frames_reg <= frames_reg + 32'h0000_0001;
            if (mctrl_wr) rate_mask_reg <= wb_dat_i[3:0];
            if (hit(wb_adr_i, `LMC_ADR_TBL_IDX)) tbl_idx_reg <= wb_dat_i[11:0];
            if (hit(wb_adr_i, `LMC_ADR_VID)) begin
                vid_reg      <= wb_dat_i[11:0];
                vid_mode_reg <= lmc_pkg::lmc_vid_t'(wb_dat_i[13:12]);
            end
        end
    end

    // Table writes; frame clear is later than software so hardware wins
    always_ff @(posedge clk) begin
        if (hit(wb_adr_i, `LMC_ADR_L2CP)) l2cp_mem[tbl_idx_reg] <= wb_dat_i[8:0];
        if (hit(wb_adr_i, `LMC_ADR_SVC))  svc_mem[tbl_idx_reg[8:0]] <= wb_dat_i[12:0];
        if (hit(wb_adr_i, `LMC_ADR_PORT)) port_mem[tbl_idx_reg[3:0]] <= wb_dat_i[3:0];
        if (hit(wb_adr_i, `LMC_ADR_MIP_CFG)) begin
            // Word [31:15] mirrors the entry fields, copy-once on top
            mip_mem[idx7].copy_once     <= wb_dat_i[31];
            mip_mem[idx7].rate_class    <= wb_dat_i[30:29];
            mip_mem[idx7].inner         <= wb_dat_i[28];
            mip_mem[idx7].queue         <= wb_dat_i[27:25];
            mip_mem[idx7].generic_act   <= lmc_pkg::lmc_act_t'(wb_dat_i[24:23]);
            mip_mem[idx7].ring_act      <= lmc_pkg::lmc_act_t'(wb_dat_i[22:21]);
            mip_mem[idx7].linktrace_en  <= wb_dat_i[20];
            mip_mem[idx7].loopback_en   <= wb_dat_i[19];
            mip_mem[idx7].continuity_en <= wb_dat_i[18];
            mip_mem[idx7].level         <= wb_dat_i[17:15];
        end
        if (hit(wb_adr_i, `LMC_ADR_MIP_OPC)) mip_mem[idx7][55:48] <= wb_dat_i[7:0];
        if (hit(wb_adr_i, `LMC_ADR_MAC_LO))  mip_mem[idx7][31:0]  <= wb_dat_i;
        if (hit(wb_adr_i, `LMC_ADR_MAC_HI))  mip_mem[idx7][47:32] <= wb_dat_i[15:0];
        if (sweep_set) mip_mem[sw_idx].copy_once <= 1'b1;
        if (clear_once) mip_mem[mp_index].copy_once <= 1'b0;
    end

    // Read mux
    wire [31:0] rd_mux =
        (wb_adr_i == `LMC_ADR_MIP_CTRL) ? {27'h0, set_cmd_reg, rate_mask_reg} :
        (wb_adr_i == `LMC_ADR_STATUS)   ? frames_reg :
        (wb_adr_i == `LMC_ADR_TBL_IDX)  ? {20'h0, tbl_idx_reg} :
        (wb_adr_i == `LMC_ADR_MIP_CFG)  ? {mip_mem[idx7].copy_once, 31'h0} :
        (wb_adr_i == `LMC_ADR_MIP_OPC)  ? {24'h00_0000, mip_mem[idx7].generic_opcode} :
        (wb_adr_i == `LMC_ADR_VID)      ? {18'h0, vid_mode_reg, vid_reg} :
        32'h0000_0000;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= bus_req ? rd_mux : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign result_o = res_reg;
endmodule : lmc_classifier
`default_nettype wire

// ### bench/lmc_classifier_sva.sv
// Checker for the classifier bus handshake and frame decisions
`timescale 1ns/1ps
`default_nettype none
module lmc_classifier_sva #(
    parameter int N_MIP = 128
) (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o,
    input wire lmc_pkg::lmc_frame_t  frame_i,
    input wire lmc_pkg::lmc_result_t result_o
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_res_follow: assert property (frame_i.valid |=> result_o.valid)
        else $error("no decision one cycle after a frame");
    a_res_quiet: assert property ($rose(resetn) |-> !wb_ack_o && !result_o.valid)
        else $error("outputs active right after reset");
    a_skip_done: assert property (
        frame_i.valid && (frame_i.upstream_redirect || frame_i.upstream_discard)
        |=> result_o.fwd == lmc_pkg::LMC_FWD_NORMAL)
        else $error("profile applied to a frame already handled");
    a_prof_point: assert property (
        result_o.valid && !$past(frame_i.is_oam)
        && result_o.fwd inside {lmc_pkg::LMC_FWD_PEER, lmc_pkg::LMC_FWD_DISCARD}
        |-> result_o.pipeline_point == lmc_pkg::LMC_PP_CLM)
        else $error("profile decision without lookup point");
    a_mip_point: assert property (
        result_o.valid
        && result_o.pipeline_point inside {lmc_pkg::LMC_PP_OUTER, lmc_pkg::LMC_PP_INNER}
        |-> $past(frame_i.valid && frame_i.maintenance_point_select_action))
        else $error("maintenance point position without select action");
    a_mip_gate: assert property (
        frame_i.valid && !frame_i.maintenance_point_select_action
        && !frame_i.upstream_redirect && frame_i.dmac[47:8] != 40'h0180_C200_00
        |=> !result_o.cpu_copy && !result_o.cpu_redirect)
        else $error("CPU action without select action");
endmodule // lmc_classifier_sva
bind lmc_classifier lmc_classifier_sva #(.N_MIP(N_MIP)) u_sva (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .frame_i(frame_i), .result_o(result_o));
`default_nettype wire

// ### bench/lmc_upstream.sv
// Upstream pipeline model presenting one descriptor per request
`timescale 1ns/1ps
`default_nettype none
module lmc_upstream (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire lmc_pkg::lmc_frame_t req,
    output var lmc_pkg::lmc_frame_t  frame_o
);
    // Idle fields flip each cycle so a stale descriptor never looks real
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_o <= '0;
        end else if (req.valid) begin
            frame_o <= req;
        end else begin
            frame_o <= {1'b0, ~frame_o[$bits(frame_o)-2:0]};
        end
    end
endmodule // lmc_upstream
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the classifier
`timescale 1ns/1ps
`default_nettype none
`include "lmc_params.svh"
module tb;
    typedef struct packed {
        lmc_pkg::lmc_frame_t f;
        logic [9:0]          e;
    } lmc_row_t;
    localparam logic [47:0] OAD = 48'h0A00_0000_0034;
    localparam logic [47:0] LBD = 48'h0011_2233_4455;
    localparam logic [47:0] BPD = 48'h0180_C200_0000;
    logic                 clk;
    logic                 resetn;
    logic [7:0]           adr;
    logic [31:0]          wdat;
    logic                 we;
    logic                 cyc;
    logic [31:0]          rdat;
    logic                 ack;
    logic [31:0]          rd;
    lmc_pkg::lmc_frame_t  req;
    lmc_pkg::lmc_frame_t  frame;
    lmc_pkg::lmc_result_t res;
    wire logic [9:0]      got;
    lmc_row_t             rows [13];
    int                   err_total;
    int                   n_tests;
    // Port profile 3 sits at table profile 67, after the 64 service ones
    logic [39:0] cfg [18] = '{
        {`LMC_ADR_TBL_IDX, 32'h0000_0002}, {`LMC_ADR_PORT, 32'h0000_0003},
        {`LMC_ADR_TBL_IDX, 32'h0000_0005}, {`LMC_ADR_SVC, 32'h0000_007F},
        {`LMC_ADR_TBL_IDX, 32'h0000_0006}, {`LMC_ADR_SVC, 32'h0000_0480},
        {`LMC_ADR_TBL_IDX, 32'h0000_0862}, {`LMC_ADR_L2CP, 32'h0000_0150},
        {`LMC_ADR_TBL_IDX, 32'h0000_0871}, {`LMC_ADR_L2CP, 32'h0000_018E},
        {`LMC_ADR_TBL_IDX, 32'h0000_012F}, {`LMC_ADR_L2CP, 32'h0000_0087},
        {`LMC_ADR_TBL_IDX, 32'h0000_007F}, {`LMC_ADR_MIP_CFG, 32'h47DE_0000},
        {`LMC_ADR_MIP_OPC, 32'h0000_0030}, {`LMC_ADR_MAC_LO, 32'h2233_4455},
        {`LMC_ADR_MAC_HI, 32'h0000_0011}, {`LMC_ADR_VID, 32'h0000_2064}};
    assign got = {res.fwd, res.cpu_copy, res.cpu_redirect, res.discard,
                  res.class_of_service_id, res.pipeline_point};
    lmc_upstream u_up (.clk(clk), .resetn(resetn), .req(req), .frame_o(frame));
    lmc_classifier #(.N_MIP(128)) uut (
        .clk(clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_dat_o(rdat), .wb_ack_o(ack), .frame_i(frame), .result_o(res));
    function automatic lmc_pkg::lmc_frame_t mk(logic [8:0] s, logic [47:0] da,
        logic [2:0] l, logic [7:0] op, logic [11:0] v);
        lmc_pkg::lmc_frame_t f;
        f = '0;
        f.valid = 1'b1;
        f.service_index = s;
        f.port = 4'h2;
        f.dmac = da;
        f.class_of_service_id = 3'h3;
        f.is_oam = (op != 8'h00);
        f.maintenance_point_select_action = (op != 8'h00);
        f.maintenance_level = l;
        f.opcode = op;
        f.tag_count = 2'h1;
        f.oam_tag_count_action = 2'h1;
        f.outer_vid = v;
        f.maintenance_point_index = 7'h7F;
        return f;
    endfunction
    function automatic logic [9:0] ex(logic [1:0] w, logic [2:0] a, logic [2:0] c,
        logic [1:0] p);
        return {w, a, c, p};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Waits for ack itself; the latency is never assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr  <= a;
        wdat <= d;
        we   <= w;
        cyc  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) err_total++;
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic send(input lmc_pkg::lmc_frame_t f);
        @(posedge clk);
        req <= f;
        @(posedge clk);
        req.valid <= 1'b0;
        // Decision stands one cycle only; look at it mid-cycle
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 20000);
        err_total++;
        conclude;
    end
    initial begin
        lmc_pkg::lmc_frame_t f;
        int n;
        err_total = 0;
        n_tests = 0;
        {resetn, adr, wdat, we, cyc, req} = '0;
        rows[0] = '{mk(9'h5, BPD + 48'h02, 3'h0, 8'h00, 12'h0), ex(2'h2, 3'h2, 3'h3, 2'h1)};
        rows[1] = '{mk(9'h5, BPD + 48'h21, 3'h0, 8'h00, 12'h0), ex(2'h3, 3'h1, 3'h6, 2'h1)};
        rows[2] = '{mk(9'h6, BPD + 48'h0F, 3'h0, 8'h00, 12'h0), ex(2'h1, 3'h0, 3'h3, 2'h0)};
        rows[3] = '{mk(9'h0, BPD + 48'h02, 3'h0, 8'h00, 12'h0), ex(2'h2, 3'h2, 3'h3, 2'h1)};
        rows[4] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_CCM, 12'h64), ex(2'h0, 3'h4, 3'h3, 2'h0)};
        rows[5] = '{mk(9'h5, OAD, 3'h3, `LMC_OPC_CCM, 12'h64), ex(2'h0, 3'h0, 3'h3, 2'h0)};
        rows[6] = '{mk(9'h5, LBD, 3'h4, `LMC_OPC_LBM, 12'h64), ex(2'h0, 3'h2, 3'h3, 2'h2)};
        rows[7] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_LBM, 12'h64), ex(2'h0, 3'h0, 3'h3, 2'h0)};
        rows[8] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_LTM, 12'h64), ex(2'h0, 3'h2, 3'h3, 2'h2)};
        rows[9] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_RAPS, 12'h64), ex(2'h0, 3'h2, 3'h3, 2'h2)};
        rows[10] = '{mk(9'h5, OAD, 3'h4, 8'h30, 12'h64), ex(2'h0, 3'h1, 3'h3, 2'h2)};
        rows[11] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_CCM, 12'h65), ex(2'h0, 3'h0, 3'h3, 2'h0)};
        rows[12] = '{mk(9'h5, OAD, 3'h4, `LMC_OPC_CCM, 12'h64), ex(2'h0, 3'h0, 3'h3, 2'h0)};
        rows[12].f.maintenance_point_select_action = 1'b0;
        repeat (4) @(posedge clk);
        chk({ack, res}, 32'h0000_0000);
        resetn <= 1'b1;
        foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
        bus(1'b0, `LMC_ADR_MIP_OPC, 32'h0000_0000);
        chk(rd, 32'h0000_0030);
        bus(1'b0, 8'h3C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("register setup done");
        // Rows 0-3 profiles, 4-12 maintenance point
        foreach (rows[i]) begin
            send(rows[i].f);
            chk(got, rows[i].e);
        end
        $display("frame table done");
        f = rows[0].f;
        f.upstream_redirect = 1'b1;
        send(f);
        chk(res.fwd, lmc_pkg::LMC_FWD_NORMAL);
        f = rows[6].f;
        f.tag_check_enable = 1'b1;
        f.oam_tag_count_action = 2'h2;
        send(f);
        chk(got, ex(2'h0, 3'h0, 3'h3, 2'h0));
        f.oam_tag_count_action = 2'h1;
        send(f);
        chk(got, rows[6].e);
        bus(1'b1, `LMC_ADR_VID, 32'h0000_3064);
        f = rows[8].f;
        f.tag_count = 2'h0;
        send(f);
        chk(got, rows[8].e);
        // Continuity copy off, so only the copy-once bit lets a frame out
        bus(1'b1, `LMC_ADR_MIP_CFG, 32'h47DA_0000);
        // Mask 4'hB misses rate class 2, mask 4'h4 hits it
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `LMC_ADR_MIP_CTRL, {27'h0, 1'b1, (k == 1) ? 4'h4 : 4'hB});
            n = 0;
            do begin
                bus(1'b0, `LMC_ADR_MIP_CTRL, 32'h0000_0000);
                n++;
            end while (rd[4] !== 1'b0 && n < 200);
            chk(rd[4], 1'b0);
            bus(1'b0, `LMC_ADR_MIP_CFG, 32'h0000_0000);
            chk(rd[31], k[0]);
        end
        send(rows[4].f);
        chk(got, rows[4].e);
        bus(1'b0, `LMC_ADR_MIP_CFG, 32'h0000_0000);
        chk(rd[31], 1'b0);
        send(rows[4].f);
        chk(got, ex(2'h0, 3'h0, 3'h3, 2'h0));
        $display("copy-once done");
        bus(1'b1, `LMC_ADR_MIP_CFG, 32'h57DE_0000);
        send(rows[9].f);
        chk({res.cpu_queue, got}, {3'h3, ex(2'h0, 3'h2, 3'h3, 2'h3)});
        send(rows[4].f);
        chk(got, rows[4].e);
        $display("inner position done");
        conclude;
    end
endmodule // tb
`default_nettype wire
